// file: hdl/wdep_top.sv
`timescale 1ns/1ps
// Summary of operation
// RQ1: prescale code 11111 is reserved and gives the minimum 1:32 interval.
// RQ2: the software watchdog enable sits at bit 0 of the control register.
// RQ3: the software enable is ignored when the configuration field is 00 or 1x.
// RQ4: with configuration field 01 the watchdog runs while the software enable is 1 only.
// RQ5: timing comes from the nominal 31 kHz low-frequency oscillator, so periods are approximate.
// RQ6: each legal prescale code (00000 to 10010) selects a power-of-two ratio, doubling per step, 01101 giving 1:262144.
// RQ7: codes 10011 and above are reserved and give the minimum interval.
// RQ8: while enabled the watchdog counts prescaled ticks and times out unless cleared.
module wdep_top #(
  parameter int CNT_W = 24
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // oscillator and configuration word pins
  input wire logic LOW_FREQ_INTERNAL_OSC,
  input wire logic [1:0] CFG_WATCHDOG_ENABLE_FIELD,
  // watchdog outputs
  output logic TIMEOUT_FLAG,
  output logic WATCHDOG_RUNNING,
  // axi4-lite write address
  input wire logic [wdep_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // read address
  input wire logic [wdep_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  // counter must reach the largest legal ratio; the 64-bit limit math caps the top end
  if (CNT_W < 24 || CNT_W > 30) begin : g_bad_cnt_w
    $error("CNT_W must hold the largest prescale ratio");
  end

  wdep_pkg::wdep_ctrl_t ctrl_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic timeout_reg;
  logic [1:0] osc_sync_reg;
  logic [1:0] cfg_sync0_reg;
  logic [1:0] cfg_sync1_reg;
  logic osc_last_reg;
  logic osc_tick;
  logic running;
  logic [4:0] ratio_log2;
  logic clear_req;

  // ratio exponent for a prescale code; reserved codes fall back to 1:32
  function automatic logic [4:0] ratio_of(input logic [4:0] code);
    if (code > wdep_pkg::PS_MAX_LEGAL) begin
      ratio_of = 5'(wdep_pkg::MIN_RATIO_LOG2); // RQ1 RQ7
    end else begin
      ratio_of = 5'(code + 5'(wdep_pkg::MIN_RATIO_LOG2)); // RQ6
    end
  endfunction

  // pins from other domains pass two flops first
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      osc_sync_reg <= 2'h0;
      cfg_sync0_reg <= 2'h0;
      cfg_sync1_reg <= 2'h0;
      osc_last_reg <= 1'b0;
    end else begin
      osc_sync_reg <= {osc_sync_reg[0], LOW_FREQ_INTERNAL_OSC};
      cfg_sync0_reg <= CFG_WATCHDOG_ENABLE_FIELD;
      cfg_sync1_reg <= cfg_sync0_reg;
      osc_last_reg <= osc_sync_reg[1];
    end
  end

  // one tick per oscillator rising edge, at nominal 31 kHz
  assign osc_tick = osc_sync_reg[1] && !osc_last_reg; // RQ5

  // 00 keeps it off, 1x keeps it on, 01 hands control to software
  always_comb begin
    unique case (cfg_sync1_reg)
      wdep_pkg::CFG_OFF: running = 1'b0; // RQ3
      wdep_pkg::CFG_SW: running = ctrl_reg.sw_enable; // RQ4
      default: running = 1'b1; // RQ3
    endcase
  end

  assign ratio_log2 = ratio_of(ctrl_reg.prescale);

  // axi write: address and data taken in either order, held until both present
  logic aw_full_reg, w_full_reg, bvalid_reg;
  logic [wdep_pkg::ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg;
  logic do_write;

  assign S_AXI_AWREADY = !aw_full_reg && !bvalid_reg;
  assign S_AXI_WREADY = !w_full_reg && !bvalid_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bresp_reg <= wdep_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA;
        wstrb_reg <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (awaddr_reg == wdep_pkg::ADDR_CONTROL
                      || awaddr_reg == wdep_pkg::ADDR_CLEAR
                      || awaddr_reg == wdep_pkg::ADDR_STATUS)
                     ? wdep_pkg::RESP_OKAY : wdep_pkg::RESP_SLVERR;
      end else if (bvalid_reg && S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;

  // control register; only byte lane 0 carries bits
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_reg <= wdep_pkg::wdep_ctrl_t'(wdep_pkg::CONTROL_RESET[5:0]);
    end else if (do_write && awaddr_reg == wdep_pkg::ADDR_CONTROL && wstrb_reg[0]) begin
      ctrl_reg.sw_enable <= wdata_reg[wdep_pkg::SWEN_BIT]; // RQ2
      ctrl_reg.prescale <= wdata_reg[wdep_pkg::PS_LSB +: wdep_pkg::PS_W];
    end
  end

  // any write to the clear address restarts the interval
  assign clear_req = do_write && awaddr_reg == wdep_pkg::ADDR_CLEAR;

  // interval counter; stopping also clears it so a restart gets a full interval
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_reg <= '0;
      timeout_reg <= 1'b0;
    end else begin
      if (!running || clear_req) begin
        cnt_reg <= '0;
      end else if (osc_tick) begin
        if (cnt_reg == CNT_W'((64'h1 << ratio_log2) - 64'h1)) begin
          cnt_reg <= '0;
          timeout_reg <= 1'b1; // RQ8
        end else begin
          cnt_reg <= cnt_reg + 1'b1; // RQ8
        end
      end
      // set wins over a clear in the same cycle
      if (do_write && awaddr_reg == wdep_pkg::ADDR_STATUS && wstrb_reg[0]
          && wdata_reg[wdep_pkg::ST_TO_BIT]
          && !(running && osc_tick && !clear_req
               && cnt_reg == CNT_W'((64'h1 << ratio_log2) - 64'h1))) begin
        timeout_reg <= 1'b0;
      end
    end
  end

  assign TIMEOUT_FLAG = timeout_reg;
  assign WATCHDOG_RUNNING = running;

  // axi read
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  assign S_AXI_ARREADY = !rvalid_reg;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= wdep_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= wdep_pkg::RESP_OKAY;
      unique case (S_AXI_ARADDR)
        wdep_pkg::ADDR_CONTROL: rdata_reg <= {26'h0, ctrl_reg};
        wdep_pkg::ADDR_STATUS: rdata_reg <= {30'h0, timeout_reg, running};
        wdep_pkg::ADDR_CLEAR: rdata_reg <= 32'h0;
        default: begin
          rdata_reg <= 32'h0;
          rresp_reg <= wdep_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

  chk_reserved_min: assert property (@(posedge MCLK) disable iff (!ARST_N)
    ctrl_reg.prescale > wdep_pkg::PS_MAX_LEGAL |-> ratio_log2 == 5'h5) // RQ1 RQ7
    else $error("reserved prescale not at minimum");
  chk_ratio_double: assert property (@(posedge MCLK) disable iff (!ARST_N)
    ctrl_reg.prescale == 5'h0d |-> ratio_log2 == 5'h12) // RQ6
    else $error("code 01101 not 1:262144");
  chk_swen_write: assert property (@(posedge MCLK) disable iff (!ARST_N)
    do_write && awaddr_reg == wdep_pkg::ADDR_CONTROL && wstrb_reg[0]
    |=> ctrl_reg.sw_enable == $past(wdata_reg[0])) // RQ2
    else $error("software enable not at bit 0");
  chk_cfg_ignore: assert property (@(posedge MCLK) disable iff (!ARST_N)
    cfg_sync1_reg != wdep_pkg::CFG_SW |-> running == cfg_sync1_reg[1]) // RQ3
    else $error("software enable not ignored");
  chk_cfg_sw: assert property (@(posedge MCLK) disable iff (!ARST_N)
    cfg_sync1_reg == wdep_pkg::CFG_SW |-> running == ctrl_reg.sw_enable) // RQ4
    else $error("software enable not obeyed");
  chk_tick_edge: assert property (@(posedge MCLK) disable iff (!ARST_N)
    osc_tick |=> !osc_tick) // RQ5
    else $error("oscillator tick longer than one cycle");
  chk_stop_clears: assert property (@(posedge MCLK) disable iff (!ARST_N)
    !running |=> cnt_reg == '0) // RQ8
    else $error("counter runs while stopped");
  chk_timeout_cause: assert property (@(posedge MCLK) disable iff (!ARST_N)
    $rose(timeout_reg) |-> $past(running && osc_tick)) // RQ8
    else $error("timeout without an elapsed tick");
endmodule

// file: inc/wdep_pkg.sv
package wdep_pkg;
  // register map, byte addresses on the AXI4-Lite slave
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_CLEAR = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam int ADDR_W = 4;
  // control register layout
  localparam int SWEN_BIT = 0;
  localparam int PS_LSB = 1;
  localparam int PS_W = 5;
  localparam logic [7:0] CONTROL_RESET = 8'h16;
  localparam logic [7:0] CONTROL_MASK = 8'h3f;
  // prescale codes
  localparam logic [4:0] PS_MAX_LEGAL = 5'h12;
  localparam int MIN_RATIO_LOG2 = 5;
  // configuration enable field
  localparam logic [1:0] CFG_OFF = 2'h0;
  localparam logic [1:0] CFG_SW = 2'h1;
  // oscillator
  localparam int OSC_HZ = 31000;
  localparam int MCLK_HZ = 100000000;
  // status bits
  localparam int ST_RUN_BIT = 0;
  localparam int ST_TO_BIT = 1;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [4:0] prescale;
    logic sw_enable;
  } wdep_ctrl_t;
endpackage

// file: bench/tb_wdep_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin \
  total_checks++; \
  if ((a) !== (b)) begin \
    err_count++; \
    $display("ERROR %0t mismatch", $time); \
  end \
end
module tb_wdep_top;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic osc = 1'b0;
  logic [1:0] cfg = 2'h0;
  logic to_flag, running, awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [31:0] rdata, rd;
  logic [1:0] bresp, rresp, rs;
  int err_count = 0;
  int total_checks = 0;

  wdep_top uut (.MCLK(mclk), .ARST_N(arst_n), .LOW_FREQ_INTERNAL_OSC(osc),
    .CFG_WATCHDOG_ENABLE_FIELD(cfg), .TIMEOUT_FLAG(to_flag), .WATCHDOG_RUNNING(running),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  initial begin
    forever #5 mclk = ~mclk;
  end

  task close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    rs = bresp;
    bready <= 1'b0;
    if (bvalid !== 1'b1) begin
      $display("ERROR %0t write response timeout", $time);
      err_count++;
      close_out();
    end
    @(posedge mclk);
  endtask

  task rdr(input logic [3:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (rvalid !== 1'b1) begin
      $display("ERROR %0t read response timeout", $time);
      err_count++;
      close_out();
    end
    @(posedge mclk);
  endtask

  // n oscillator periods, each long enough for the two-flop synchroniser
  task tick(input int n);
    repeat (n) begin
      osc <= 1'b1;
      repeat (4) @(posedge mclk);
      osc <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask

  task t_reset;
    `CHK(running, 1'b0)
    rdr(wdep_pkg::ADDR_CONTROL);
    `CHK(rd, {24'h0, wdep_pkg::CONTROL_RESET})
    rdr(wdep_pkg::ADDR_STATUS);
    `CHK(rd, 32'h0)
  endtask

  task t_soft;
    cfg <= wdep_pkg::CFG_SW;
    wr(wdep_pkg::ADDR_CONTROL, 32'h1);
    `CHK(rs, wdep_pkg::RESP_OKAY)
    `CHK(running, 1'b1)
    rdr(wdep_pkg::ADDR_STATUS);
    `CHK(rd[wdep_pkg::ST_RUN_BIT], 1'b1)
    wr(wdep_pkg::ADDR_CONTROL, 32'h0);
    `CHK(running, 1'b0)
  endtask

  task t_ignored;
    wr(wdep_pkg::ADDR_CONTROL, 32'h1);
    cfg <= wdep_pkg::CFG_OFF;
    repeat (4) @(posedge mclk);
    `CHK(running, 1'b0)
    wr(wdep_pkg::ADDR_CONTROL, 32'h0);
    cfg <= 2'h2;
    repeat (4) @(posedge mclk);
    `CHK(running, 1'b1)
    cfg <= 2'h3;
    repeat (4) @(posedge mclk);
    `CHK(running, 1'b1)
  endtask

  // timeout must land on exactly the n-th tick after a restart
  task t_ratio(input logic [4:0] code, input int n);
    cfg <= 2'h2;
    wr(wdep_pkg::ADDR_CONTROL, {26'h0, code, 1'b0});
    // partial count first, so a clear that did nothing times out early
    tick(3);
    wr(wdep_pkg::ADDR_CLEAR, 32'h1);
    wr(wdep_pkg::ADDR_STATUS, 32'h2);
    `CHK(to_flag, 1'b0)
    tick(n - 1);
    `CHK(to_flag, 1'b0)
    tick(1);
    `CHK(to_flag, 1'b1)
  endtask

  task t_unmapped;
    wr(4'hc, 32'h3f);
    `CHK(rs, wdep_pkg::RESP_SLVERR)
    rdr(4'hc);
    `CHK(rs, wdep_pkg::RESP_SLVERR)
    rdr(wdep_pkg::ADDR_CONTROL);
    `CHK(rd, 32'h3e)
    // lane 0 strobe low must leave the control bits alone
    wstrb <= 4'he;
    wr(wdep_pkg::ADDR_CONTROL, 32'h1);
    wstrb <= 4'hf;
    rdr(wdep_pkg::ADDR_CONTROL);
    `CHK(rd, 32'h3e)
  endtask

  task t_code;
    wr(wdep_pkg::ADDR_CONTROL, {26'h0, 5'h0d, 1'b0});
    rdr(wdep_pkg::ADDR_CONTROL);
    `CHK(rd, 32'h1a)
  endtask

  // reset in mid-run drops a standing timeout and restores the control word
  task t_rearm;
    `CHK(to_flag, 1'b1)
    arst_n <= 1'b0;
    @(posedge mclk);
    `CHK(to_flag, 1'b0)
    @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK(running, 1'b1)
    rdr(wdep_pkg::ADDR_CONTROL);
    `CHK(rd, {24'h0, wdep_pkg::CONTROL_RESET})
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_soft();
    t_ignored();
    t_ratio(5'h00, 32);
    t_ratio(5'h01, 64);
    t_ratio(5'h13, 32);
    t_ratio(5'h1f, 32);
    t_unmapped();
    t_code();
    t_rearm();
    close_out();
  end
endmodule
